// >>> core/supply_lockout_pkg.sv
package supply_lockout_pkg;
  // ****************
  // register map
  // ****************
  localparam logic [7:0] OFF_REG_UV_CTRL = 8'h98;
  localparam logic [7:0] OFF_SLOPE_ONE = 8'h9C;
  localparam logic [7:0] OFF_IN_LOCK_CTRL = 8'hA0;
  localparam logic [7:0] OFF_IN_UV_THRESH = 8'hA4;
  localparam logic [7:0] OFF_IN_OV_THRESH = 8'hA8;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'hAC;
  localparam logic [7:0] OFF_IRQ_MASK = 8'hB0;
  localparam int ADDR_W = 8;
  // ****************
  // input lockout control fields
  // ****************
  localparam int B_UV_EN = 7;
  localparam int B_UV_STAT = 6;
  localparam int B_UV_RISE = 5;
  localparam int B_UV_FALL = 4;
  localparam int B_OV_EN = 3;
  localparam int B_OV_STAT = 2;
  localparam int B_OV_RISE = 1;
  localparam int B_OV_FALL = 0;
  // ****************
  // regulator control and slope fields
  // ****************
  localparam int B_REG_EN = 7;
  localparam int B_REG_STAT = 6;
  localparam int B_REG_RISE = 5;
  localparam int B_REG_FALL = 4;
  localparam int REG_THR_W = 2;
  localparam int B_SLOPE_BYP = 6;
  localparam int CODE_W = 6;
  // ****************
  // interrupt status bits
  // ****************
  localparam int IRQ_UV = 0;
  localparam int IRQ_OV = 1;
  localparam int IRQ_REG = 2;
  localparam int IRQ_N = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [5:0] CODE_RESET = 6'h00;
endpackage : supply_lockout_pkg

// >>> core/supply_lockout_monitor_regs.sv
`timescale 1ns/1ps
// How it works
// - flags set on edges, ignoring enables
// - undervolt status bit six, read-only
// - overvolt status bit two, read-only
// - undervolt with enable kills gate drives
// - overvolt with enable kills gate drives
// - undervolt lockout clears when voltage recovers
// - overvolt lockout clears when voltage recovers
// - undervolt flag on selected rise/fall edges
// - overvolt flag on selected rise/fall edges
// - undervolt threshold six-bit code, top zero
// - overvolt threshold six-bit code, top zero
// - below range still reports undervoltage
// - regulator enable bit seven, status six
// - regulator flag on selected edges
// - regulator threshold two bits, 3-2 zero
// - bypass bit drives slope bypass output
// - slope six-bit code, bit seven zero
module supply_lockout_monitor_regs
  import supply_lockout_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog comparators, high = condition present
  input wire logic in_undervolt_cmp,
  input wire logic in_overvolt_cmp,
  input wire logic regulator_undervolt_cmp,
  // analog settings
  output logic [CODE_W-1:0] input_undervolt_threshold,
  output logic [CODE_W-1:0] input_overvolt_threshold,
  output logic [REG_THR_W-1:0] regulator_undervolt_threshold,
  output logic regulator_undervolt_enable,
  output logic slope_bypass,
  output logic [CODE_W-1:0] slope_slew_code,
  // gate drive permission and interrupt
  output logic gate_drive_one_enable,
  output logic gate_drive_two_enable,
  output logic irq
);

  // ****************
  // state
  // ****************
  typedef struct packed {
    // two-flop synchronisers and last settled level
    logic [1:0] uv_sync;
    logic [1:0] ov_sync;
    logic [1:0] reg_sync;
    logic uv_prev;
    logic ov_prev;
    logic reg_prev;
    // input lockout control
    logic uv_en;
    logic uv_rise;
    logic uv_fall;
    logic ov_en;
    logic ov_rise;
    logic ov_fall;
    // regulator undervolt control
    logic reg_en;
    logic reg_rise;
    logic reg_fall;
    logic [REG_THR_W-1:0] reg_thr;
    // analog codes
    logic [CODE_W-1:0] uv_thr;
    logic [CODE_W-1:0] ov_thr;
    logic slope_byp;
    logic [CODE_W-1:0] slope_code;
    // sticky flags and their mask
    logic [IRQ_N-1:0] irq_stat;
    logic [IRQ_N-1:0] irq_mask;
    // read data, latched in the setup cycle
    logic [31:0] rdata;
    // gate drivers allowed
    logic gate_ok;
  } state_type;

  state_type state_r;
  state_type state_nxt;

  // ****************
  // helpers
  // ****************
  function automatic logic edge_hit(input logic now, input logic prev,
                                    input logic rise_en,
                                    input logic fall_en);
    edge_hit = (rise_en && now && !prev) || (fall_en && !now && prev);
  endfunction : edge_hit

  // registers are a byte wide, upper bus bits read zero
  function automatic logic [31:0] widen(input logic [7:0] b);
    widen = {24'h000000, b};
  endfunction : widen

  // six-bit code in the low bits, top bits read zero
  function automatic logic [7:0] code_byte(input logic [CODE_W-1:0] c);
    code_byte = 8'h00;
    code_byte[CODE_W-1:0] = c;
  endfunction : code_byte

  function automatic logic [7:0] flag_byte(input logic [IRQ_N-1:0] f);
    flag_byte = 8'h00;
    flag_byte[IRQ_N-1:0] = f;
  endfunction : flag_byte

  function automatic logic [7:0] lock_byte(input state_type s);
    lock_byte = 8'h00;
    lock_byte[B_UV_EN] = s.uv_en;
    // undervolt status is the settled level
    // comparator itself covers the below-range case
    lock_byte[B_UV_STAT] = s.uv_prev;
    lock_byte[B_UV_RISE] = s.uv_rise;
    lock_byte[B_UV_FALL] = s.uv_fall;
    lock_byte[B_OV_EN] = s.ov_en;
    // overvolt status is the settled level
    lock_byte[B_OV_STAT] = s.ov_prev;
    lock_byte[B_OV_RISE] = s.ov_rise;
    lock_byte[B_OV_FALL] = s.ov_fall;
  endfunction : lock_byte

  function automatic logic [7:0] reg_byte(input state_type s);
    reg_byte = 8'h00;
    reg_byte[B_REG_EN] = s.reg_en;
    reg_byte[B_REG_STAT] = s.reg_prev;
    reg_byte[B_REG_RISE] = s.reg_rise;
    reg_byte[B_REG_FALL] = s.reg_fall;
    // threshold in the low bits, bits 3-2 stay zero
    reg_byte[REG_THR_W-1:0] = s.reg_thr;
  endfunction : reg_byte

  function automatic logic [7:0] slope_byte(input state_type s);
    slope_byte = code_byte(s.slope_code);
    slope_byte[B_SLOPE_BYP] = s.slope_byp;
  endfunction : slope_byte

  // write helpers: status bits are not stored, so they are skipped
  function automatic state_type lock_write(input state_type s,
                                           input logic [31:0] d);
    lock_write = s;
    lock_write.uv_en = d[B_UV_EN];
    lock_write.uv_rise = d[B_UV_RISE];
    lock_write.uv_fall = d[B_UV_FALL];
    lock_write.ov_en = d[B_OV_EN];
    lock_write.ov_rise = d[B_OV_RISE];
    lock_write.ov_fall = d[B_OV_FALL];
  endfunction : lock_write

  function automatic state_type reg_write(input state_type s,
                                          input logic [31:0] d);
    reg_write = s;
    reg_write.reg_en = d[B_REG_EN];
    reg_write.reg_rise = d[B_REG_RISE];
    reg_write.reg_fall = d[B_REG_FALL];
    reg_write.reg_thr = d[REG_THR_W-1:0];
  endfunction : reg_write

  function automatic state_type slope_write(input state_type s,
                                            input logic [31:0] d);
    slope_write = s;
    slope_write.slope_byp = d[B_SLOPE_BYP];
    slope_write.slope_code = d[CODE_W-1:0];
  endfunction : slope_write

  // ****************
  // bus decode
  // ****************
  logic wr;
  logic rd;
  logic sel_lock;
  logic sel_reg;
  logic sel_uv;
  logic sel_ov;
  logic sel_slope;
  logic sel_stat;
  logic sel_mask;
  logic [IRQ_N-1:0] clear_bits;

  // zero-wait slave: writes land in the access cycle; reads are
  // latched in the setup cycle so prdata comes from a flip-flop
  always_comb begin
    wr = psel && penable && pwrite;
    rd = psel && !penable && !pwrite;
    // unmapped offsets match no select, so their writes drop
    sel_lock = (paddr == OFF_IN_LOCK_CTRL);
    sel_reg = (paddr == OFF_REG_UV_CTRL);
    sel_uv = (paddr == OFF_IN_UV_THRESH);
    sel_ov = (paddr == OFF_IN_OV_THRESH);
    sel_slope = (paddr == OFF_SLOPE_ONE);
    sel_stat = (paddr == OFF_IRQ_STATUS);
    sel_mask = (paddr == OFF_IRQ_MASK);
    clear_bits = '0;
    if (wr && sel_stat) begin
      clear_bits = pwdata[IRQ_N-1:0];
    end
  end

  // ****************
  // comparator levels and edges
  // ****************
  logic uv_level;
  logic ov_level;
  logic reg_level;
  logic [IRQ_N-1:0] events;

  // only the second sync stage is looked at
  always_comb begin
    uv_level = state_r.uv_sync[1];
    ov_level = state_r.ov_sync[1];
    reg_level = state_r.reg_sync[1];
  end

  // a level held over several cycles sets its flag once
  always_comb begin
    events = '0;
    // flags ignore the lockout enables and the mask
    events[IRQ_UV] = edge_hit(uv_level, state_r.uv_prev,
                              state_r.uv_rise, state_r.uv_fall);
    events[IRQ_OV] = edge_hit(ov_level, state_r.ov_prev,
                              state_r.ov_rise, state_r.ov_fall);
    // regulator enable does not gate its flag
    events[IRQ_REG] = edge_hit(reg_level, state_r.reg_prev,
                               state_r.reg_rise, state_r.reg_fall);
  end

  // ****************
  // interrupt
  // ****************
  logic [IRQ_N-1:0] flags_nxt;
  logic irq_pending;

  always_comb begin
    // set wins over write-one-to-clear in the same cycle
    flags_nxt = (state_r.irq_stat & ~clear_bits) | events;
    irq_pending = |(state_r.irq_stat & state_r.irq_mask);
  end

  // ****************
  // lockout
  // ****************
  logic uv_lock;
  logic ov_lock;

  // no latch: lockout follows the comparator, so recovery needs no write
  always_comb begin
    // undervolt with enable stops both drives
    uv_lock = state_r.uv_en && uv_level;
    // overvolt with enable stops both drives
    ov_lock = state_r.ov_en && ov_level;
  end

  // ****************
  // read data
  // ****************
  logic [31:0] read_word;

  // built every cycle, taken only in a read setup cycle
  always_comb begin
    unique case (paddr)
      OFF_IN_LOCK_CTRL: read_word = widen(lock_byte(state_r));
      OFF_REG_UV_CTRL: read_word = widen(reg_byte(state_r));
      OFF_IN_UV_THRESH: read_word = widen(code_byte(state_r.uv_thr));
      OFF_IN_OV_THRESH: read_word = widen(code_byte(state_r.ov_thr));
      OFF_SLOPE_ONE: read_word = widen(slope_byte(state_r));
      OFF_IRQ_STATUS: read_word = widen(flag_byte(state_r.irq_stat));
      OFF_IRQ_MASK: read_word = widen(flag_byte(state_r.irq_mask));
      // unmapped offsets read zero and raise no error
      default: read_word = 32'h00000000;
    endcase
  end

  // ****************
  // next state
  // ****************
  always_comb begin
    state_nxt = state_r;
    // two-flop sync per comparator, then one more for edges
    state_nxt.uv_sync = {state_r.uv_sync[0], in_undervolt_cmp};
    state_nxt.ov_sync = {state_r.ov_sync[0], in_overvolt_cmp};
    state_nxt.reg_sync = {state_r.reg_sync[0], regulator_undervolt_cmp};
    state_nxt.uv_prev = uv_level;
    state_nxt.ov_prev = ov_level;
    state_nxt.reg_prev = reg_level;

    if (wr && sel_lock) begin
      state_nxt = lock_write(state_nxt, pwdata);
    end

    if (wr && sel_reg) begin
      state_nxt = reg_write(state_nxt, pwdata);
    end

    if (wr && sel_uv) begin
      state_nxt.uv_thr = pwdata[CODE_W-1:0];
    end

    if (wr && sel_ov) begin
      state_nxt.ov_thr = pwdata[CODE_W-1:0];
    end

    // six-bit slope code beside the bypass bit
    if (wr && sel_slope) begin
      state_nxt = slope_write(state_nxt, pwdata);
    end

    if (wr && sel_mask) begin
      state_nxt.irq_mask = pwdata[IRQ_N-1:0];
    end

    state_nxt.irq_stat = flags_nxt;

    // held until the next read setup, so the access cycle sees it
    if (rd) begin
      state_nxt.rdata = read_word;
    end

    // undervolt lockout ends as the comparator falls
    // overvolt lockout ends as the comparator falls
    state_nxt.gate_ok = !(uv_lock || ov_lock);
  end

  // ****************
  // registers
  // ****************
  // drives stay off through reset and are allowed from the first edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************
  // outputs
  // ****************
  // bus answer: always ready, never an error
  assign prdata = state_r.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // analog settings
  assign input_undervolt_threshold = state_r.uv_thr;
  assign input_overvolt_threshold = state_r.ov_thr;
  assign regulator_undervolt_threshold = state_r.reg_thr;
  assign regulator_undervolt_enable = state_r.reg_en;
  assign slope_bypass = state_r.slope_byp;
  assign slope_slew_code = state_r.slope_code;

  // both drives share one permission
  assign gate_drive_one_enable = state_r.gate_ok;
  assign gate_drive_two_enable = state_r.gate_ok;

  // level interrupt, high while an unmasked flag is set
  assign irq = irq_pending;

endmodule : supply_lockout_monitor_regs

// >>> dv/lockout_asserts.sv
`timescale 1ns/1ps
module lockout_asserts
  import supply_lockout_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // monitor
  input wire logic in_undervolt_cmp,
  input wire logic in_overvolt_cmp,
  input wire logic [CODE_W-1:0] input_undervolt_threshold,
  input wire logic [CODE_W-1:0] input_overvolt_threshold,
  input wire logic [CODE_W-1:0] slope_slew_code,
  input wire logic gate_drive_one_enable,
  input wire logic gate_drive_two_enable
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  assign wr = psel && penable && pwrite;
  a_ready_zero_wait: assert property (pready && !pslverr)
    else $error("apb answer not zero wait");
  a_unmapped_zero: assert property (psel && !penable && !pwrite &&
    paddr == 8'hC0 |=> prdata == 32'h0) else $error("unmapped read");
  a_gate_pair: assert property (
    gate_drive_one_enable == gate_drive_two_enable)
    else $error("gate drives differ");
  a_gate_recover: assert property (
    (!in_undervolt_cmp && !in_overvolt_cmp) [*4] |=> gate_drive_one_enable)
    else $error("gate not restored");
  a_gate_cause: assert property (
    $fell(gate_drive_one_enable) |->
    $past(in_undervolt_cmp, 3) || $past(in_overvolt_cmp, 3))
    else $error("gate dropped without lockout");
  a_uv_thr_write: assert property (
    wr && paddr == OFF_IN_UV_THRESH |=>
    input_undervolt_threshold == $past(pwdata[5:0]))
    else $error("uv threshold write");
  a_ov_thr_write: assert property (
    wr && paddr == OFF_IN_OV_THRESH |=>
    input_overvolt_threshold == $past(pwdata[5:0]))
    else $error("ov threshold write");
  a_slope_write: assert property (
    wr && paddr == OFF_SLOPE_ONE |=> slope_slew_code == $past(pwdata[5:0]))
    else $error("slope code write");
  a_thr_hold: assert property (
    !wr |=> $stable(input_undervolt_threshold))
    else $error("threshold changed unwritten");
endmodule : lockout_asserts

// >>> dv/tb.sv
`timescale 1ns/1ps
bind supply_lockout_monitor_regs lockout_asserts u_chk (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .in_undervolt_cmp, .in_overvolt_cmp, .input_undervolt_threshold,
  .input_overvolt_threshold, .slope_slew_code, .gate_drive_one_enable,
  .gate_drive_two_enable);
module tb;
  import supply_lockout_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq, g1, g2, rbyp, ren;
  logic [2:0] cmp = 3'h0;
  logic [5:0] uvt, ovt, slc;
  logic [1:0] rth;
  int mismatches = 0, checks = 0;
  initial forever #12.5 pclk = ~pclk;
  supply_lockout_monitor_regs DUT (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .in_undervolt_cmp(cmp[0]), .in_overvolt_cmp(cmp[1]),
    .regulator_undervolt_cmp(cmp[2]), .input_undervolt_threshold(uvt),
    .input_overvolt_threshold(ovt), .regulator_undervolt_threshold(rth),
    .regulator_undervolt_enable(ren), .slope_bypass(rbyp),
    .slope_slew_code(slc), .gate_drive_one_enable(g1),
    .gate_drive_two_enable(g2), .irq);
  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
      mismatches++;
    end
  endtask : chk
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    psel <= 0;
    penable <= 0;
    // idle edge, so a following call never re-raises psel at once
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1, a, d, r);
  endtask : wr
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    apb(0, a, 32'h0, r);
    chk(r, e);
  endtask : rchk
  logic [7:0] ad[6] = '{OFF_IN_LOCK_CTRL, OFF_IN_UV_THRESH, OFF_IN_OV_THRESH,
    OFF_SLOPE_ONE, OFF_REG_UV_CTRL, 8'hC0};
  logic [31:0] ex[6] = '{32'hBB, 32'h3F, 32'h3F, 32'h7F, 32'hB3, 32'h0};
  task automatic t_regs;
    for (int i = 0; i < 6; i++) rchk(ad[i], 32'h0);
    chk({g1, g2}, 2'b11);
    for (int i = 0; i < 6; i++) begin
      wr(ad[i], 32'hFFFF_FFFF);
      rchk(ad[i], ex[i]);
    end
    chk({uvt, ovt, slc, rth, rbyp, ren}, 22'h3FFFFF);
    for (int i = 0; i < 5; i++) wr(ad[i], 32'h0);
    chk({rbyp, ren}, 2'b00);
  endtask : t_regs
  // each edge mode of one source; lockout enabled in mode 3 (regulator enable for source 2)
  task automatic t_edge(input int s);
    int o;
    logic [7:0] a;
    logic [31:0] c;
    logic [1:0] m;
    o = (s == 1) ? 4 : 0;
    a = (s == 2) ? OFF_REG_UV_CTRL : OFF_IN_LOCK_CTRL;
    for (int k = 0; k < 4; k++) begin
      m = k;
      c = (m[1] << (B_UV_RISE - o)) | (m[0] << (B_UV_FALL - o)) |
          ((m == 3) << (B_UV_EN - o));
      wr(a, c);
      wr(OFF_IRQ_MASK, (m == 1) ? 32'h0 : 32'h7);
      rchk(OFF_IRQ_MASK, (m == 1) ? 32'h0 : 32'h7);
      wr(OFF_IRQ_STATUS, 32'h7);
      cmp[s] <= 1;
      repeat (6) @(posedge pclk);
      rchk(a, c | (1 << (B_UV_STAT - o)));
      rchk(OFF_IRQ_STATUS, 32'(m[1]) << s);
      chk(irq, m[1]);
      chk({g1, g2}, (m == 3 && s < 2) ? 2'b00 : 2'b11);
      chk(ren, s == 2 && m == 3);
      cmp[s] <= 0;
      repeat (6) @(posedge pclk);
      rchk(OFF_IRQ_STATUS, 32'(m != 0) << s);
      chk(irq, m[1]);
      chk({g1, g2}, 2'b11);
      rchk(a, c);
      wr(OFF_IRQ_STATUS, 32'h7);
      rchk(OFF_IRQ_STATUS, 32'h0);
      chk(irq, 1'b0);
    end
    wr(a, 32'h0);
  endtask : t_edge
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    t_regs;
    for (int s = 0; s < 3; s++) t_edge(s);
    results;
  end
  // watchdog: far beyond the six hundred or so cycles the run needs
  initial begin
    #(25 * 40000);
    mismatches++;
    results;
  end
endmodule : tb
